// File: verilog/tef_pkg.sv
// Constants shared by the timer event flag and request enable logic
package tef_pkg;
	// Register byte offsets
	localparam logic [11:0] TEF_DIER_OFF     = 12'h00C;
	localparam logic [11:0] TEF_SR_OFF       = 12'h010;
	// Values after reset
	localparam logic [31:0] TEF_DIER_RST     = 32'h0000_0000;
	localparam logic [31:0] TEF_SR_RST       = 32'h0000_0000;
	// Enable register field positions
	localparam int          TEF_UPD_IRQ_BIT  = 0;
	localparam int          TEF_CH_IRQ_LSB   = 1;
	localparam int          TEF_TRG_IRQ_BIT  = 6;
	localparam int          TEF_UPD_DMA_BIT  = 8;
	localparam int          TEF_CH_DMA_LSB   = 9;
	localparam int          TEF_TRG_DMA_BIT  = 14;
	// Status register field positions
	localparam int          TEF_UPD_FLG_BIT  = 0;
	localparam int          TEF_CH_FLG_LSB   = 1;
	localparam int          TEF_TRG_FLG_BIT  = 6;
	localparam int          TEF_CH_OVC_LSB   = 9;
	// Number of capture/compare channels
	localparam int          TEF_NUM_CH       = 4;
	// Implemented bits; all others are reserved and read zero
	localparam logic [31:0] TEF_DIER_MASK    = 32'h0000_5F5F;
	localparam logic [31:0] TEF_SR_MASK      = 32'h0000_1E5F;
	// Enable bits that gate the interrupt line
	localparam logic [31:0] TEF_IRQ_MASK     = 32'h0000_005F;
	// Slave mode codes
	localparam logic [2:0]  TEF_SLV_OFF      = 3'h0;
	localparam logic [2:0]  TEF_SLV_PAUSE    = 3'h5;
endpackage

// File: verilog/tef_trig_detect.sv
// Trigger input edge detector producing trigger events
`timescale 1ns/100ps
module tef_trig_detect
	import tef_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       trigger_in_i,
	input  wire logic [2:0] slave_mode_select_i,
	output logic            trig_evt_o
);
	logic trig_prev;   // Trigger level one cycle ago

	// Previous trigger level, same clock as the timer so no sync
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			trig_prev <= 1'b0;
		end else begin
			trig_prev <= trigger_in_i;
		end
	end

	// Edge qualification by slave mode
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			trig_evt_o <= 1'b0;
		end else if (slave_mode_select_i == TEF_SLV_OFF) begin
			// Slave controller off: no trigger events at all
			trig_evt_o <= 1'b0;
		end else if (slave_mode_select_i == TEF_SLV_PAUSE) begin
			// Pause gates the counter on level, so both edges count
			trig_evt_o <= trigger_in_i ^ trig_prev;
		end else begin
			// Other modes: active (rising) edge only
			trig_evt_o <= trigger_in_i & ~trig_prev;
		end
	end
endmodule

// File: verilog/tef_flags.sv
// Timer event flags, interrupt and DMA request enables, APB slave
// How it works
// - Enable bit 0 gates update interrupt
// - Bits 1-4 gate channel interrupts
// - Enable bit 6 gates trigger interrupt
// - Bit 8 gates update DMA requests
// - Bits 9-12 gate channel DMA requests
// - Bit 14 gates trigger DMA requests
// - Reserved bits read zero, keep zero
// - Update event sets flag bit 0
// - Channel 1 capture sets its flag
// - Channel 1 compare match sets flag
// - Channels 2-4 flags at bits 2-4
// - Active trigger edge sets trigger flag
// - Pause mode: both trigger edges count
// - Capture with flag set sets over-capture
// - Channels 2-4 over-capture at bits 10-12
// - Hardware sets flags, software writes zero
// - Mode 101 is pause, 000 disabled
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
module tef_flags
	import tef_pkg::*;
#(
	parameter int ADDR_W = 12                // APB address width
)(
	input  wire logic              ref_clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              update_evt_i,
	input  wire logic [3:0]        chan_capture_i,
	input  wire logic [3:0]        chan_compare_i,
	input  wire logic [3:0]        chan_input_mode_i,
	input  wire logic              trigger_in_i,
	input  wire logic [2:0]        slave_mode_select_i,
	output logic                   irq_o,
	output logic                   update_dma_req_o,
	output logic [3:0]             chan_dma_req_o,
	output logic                   trigger_dma_req_o
);
	// Expand byte strobes into a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	// Address compare on the low address bits
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [11:0] off);
		return a[11:0] == off;
	endfunction

	logic [31:0] dma_interrupt_enable; // Enable register
	logic [31:0] event_status_flags;   // Status flag register
	logic        setup_ph;             // APB setup cycle
	logic        access_ph;            // APB access cycle, always ready
	logic        wr_en_dier;           // Write to enable register
	logic        wr_en_sr;             // Write to status register
	logic        addr_ok;              // Address maps to a register
	logic [31:0] wmask;                // Strobed bit lanes
	logic [31:0] sr_clr;               // Bits software clears now
	logic [31:0] sr_set;               // Bits hardware sets now
	logic [31:0] next_sr;              // Status value for next edge
	logic [3:0]  chan_cap;             // Capture events per channel
	logic [3:0]  chan_evt;             // Capture or compare events
	logic [3:0]  chan_ovc;             // Over-capture events
	logic        trig_evt;             // Qualified trigger event

	// Trigger edge qualification lives in its own small block
	tef_trig_detect u_trig (
		.ref_clk_i           (ref_clk_i),
		.sys_rst_i           (sys_rst_i),
		.trigger_in_i        (trigger_in_i),
		.slave_mode_select_i (slave_mode_select_i),
		.trig_evt_o          (trig_evt)
	);

	// APB phase decode; zero wait states so pready is combinational
	assign setup_ph   = psel_i & ~penable_i;
	assign access_ph  = psel_i & penable_i;
	assign pready_o   = access_ph;
	assign addr_ok    = hit(paddr_i, TEF_DIER_OFF)
	                  | hit(paddr_i, TEF_SR_OFF);
	// Unmapped addresses answer with an error, writes dropped
	assign pslverr_o  = access_ph & ~addr_ok;
	assign wmask      = strb_mask(pstrb_i);
	assign wr_en_dier = access_ph & pwrite_i
	                  & hit(paddr_i, TEF_DIER_OFF);
	assign wr_en_sr   = access_ph & pwrite_i
	                  & hit(paddr_i, TEF_SR_OFF);

	// Channel events depend on the channel direction
	always_comb begin
		chan_cap = chan_input_mode_i & chan_capture_i;
		chan_evt = chan_cap
		         | (~chan_input_mode_i & chan_compare_i);
		// New capture while the channel flag is still up
		chan_ovc = chan_cap
		         & event_status_flags[TEF_CH_FLG_LSB +: TEF_NUM_CH];
		// Over-capture for every channel alike
	end

	// Hardware set vector, one bit per status flag
	always_comb begin
		sr_set = '0;
		sr_set[TEF_UPD_FLG_BIT] = update_evt_i;
		sr_set[TEF_CH_FLG_LSB +: TEF_NUM_CH] = chan_evt;
		sr_set[TEF_TRG_FLG_BIT] = trig_evt;
		sr_set[TEF_CH_OVC_LSB +: TEF_NUM_CH] = chan_ovc;
	end

	// Software clears only where it writes a zero on a strobed lane
	always_comb begin
		sr_clr = '0;
		if (wr_en_sr) begin
			sr_clr = wmask & ~pwdata_i & TEF_SR_MASK;
		end
		// Set is OR-ed last so a coincident event is kept
		next_sr = ((event_status_flags & ~sr_clr) | sr_set)
		        & TEF_SR_MASK;
	end

	// Status flags: set by hardware, cleared by writing zero
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			event_status_flags <= TEF_SR_RST;
		end else begin
			event_status_flags <= next_sr;
		end
	end

	// Enable register; reserved lanes are masked so they stay zero
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dma_interrupt_enable <= TEF_DIER_RST;
		end else if (wr_en_dier) begin
			// Byte lanes not strobed keep their old value
			dma_interrupt_enable <= ((dma_interrupt_enable & ~wmask)
			                     | (pwdata_i & wmask))
			                     & TEF_DIER_MASK;
		end
	end

	// Read data captured in the setup cycle, shown in access cycle
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup_ph) begin
			if (hit(paddr_i, TEF_DIER_OFF)) begin
				prdata_o <= dma_interrupt_enable & TEF_DIER_MASK;
			end else if (hit(paddr_i, TEF_SR_OFF)) begin
				prdata_o <= event_status_flags & TEF_SR_MASK;
			end else begin
				// Unmapped read returns zero with the error flag
				prdata_o <= 32'h0000_0000;
			end
		end
	end

	// Interrupt line: any of flags 0-4 and 6 with its enable, one cycle of lag
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(event_status_flags & dma_interrupt_enable
			         & TEF_IRQ_MASK);
		end
	end

	// DMA requests: one-cycle pulses per enabled event
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			update_dma_req_o  <= 1'b0;
			chan_dma_req_o    <= 4'h0;
			trigger_dma_req_o <= 1'b0;
		end else begin
			update_dma_req_o  <= update_evt_i
			   & dma_interrupt_enable[TEF_UPD_DMA_BIT];
			chan_dma_req_o    <= chan_evt
			   & dma_interrupt_enable[TEF_CH_DMA_LSB +: TEF_NUM_CH];
			trigger_dma_req_o <= trig_evt
			   & dma_interrupt_enable[TEF_TRG_DMA_BIT];
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	upd_flag_set_a: assert property (
		update_evt_i |=> event_status_flags[TEF_UPD_FLG_BIT])
		else $error("update event did not set flag");

	ch1_capture_a: assert property (
		chan_input_mode_i[0] && chan_capture_i[0]
		|=> event_status_flags[TEF_CH_FLG_LSB])
		else $error("channel 1 capture did not set flag");

	ch1_compare_a: assert property (
		!chan_input_mode_i[0] && chan_compare_i[0]
		|=> event_status_flags[TEF_CH_FLG_LSB])
		else $error("channel 1 compare did not set flag");

	ch4_event_a: assert property (
		(chan_input_mode_i[3] ? chan_capture_i[3] : chan_compare_i[3])
		|=> event_status_flags[TEF_CH_FLG_LSB + 3])
		else $error("channel 4 event did not set flag");

	ch_wrong_dir_a: assert property (
		!chan_input_mode_i[1] && chan_capture_i[1]
		&& !chan_compare_i[1] && !event_status_flags[2]
		|=> !event_status_flags[2])
		else $error("capture set flag of output channel");

	ch1_overcap_a: assert property (
		chan_input_mode_i[0] && chan_capture_i[0]
		&& event_status_flags[TEF_CH_FLG_LSB]
		|=> event_status_flags[TEF_CH_OVC_LSB])
		else $error("channel 1 over-capture not flagged");

	ch2_no_overcap_a: assert property (
		!event_status_flags[TEF_CH_FLG_LSB + 1]
		&& !event_status_flags[TEF_CH_OVC_LSB + 1]
		|=> !event_status_flags[TEF_CH_OVC_LSB + 1])
		else $error("channel 2 over-capture without cause");

	trig_rise_a: assert property (
		$rose(trigger_in_i) && slave_mode_select_i != TEF_SLV_OFF
		|=> ##1 event_status_flags[TEF_TRG_FLG_BIT])
		else $error("trigger edge did not set flag");

	trig_pause_fall_a: assert property (
		$fell(trigger_in_i) && slave_mode_select_i == TEF_SLV_PAUSE
		|=> ##1 event_status_flags[TEF_TRG_FLG_BIT])
		else $error("pause falling edge missed");

	sw_clear_a: assert property (
		wr_en_sr && pstrb_i[0] && !pwdata_i[0] && !update_evt_i
		|=> !event_status_flags[0])
		else $error("write zero did not clear update flag");

	set_wins_a: assert property (
		wr_en_sr && pstrb_i[0] && !pwdata_i[0] && update_evt_i
		|=> event_status_flags[0])
		else $error("clear beat coincident set");

	write_one_a: assert property (
		wr_en_sr && pstrb_i[0] && pwdata_i[0] && event_status_flags[0]
		|=> event_status_flags[0])
		else $error("writing one changed a flag");

	reserved_zero_a: assert property (
		(event_status_flags & ~TEF_SR_MASK) == 32'h0000_0000
		&& (dma_interrupt_enable & ~TEF_DIER_MASK) == 32'h0000_0000)
		else $error("reserved bit became set");

	irq_level_a: assert property (
		|(event_status_flags & dma_interrupt_enable & TEF_IRQ_MASK)
		|=> irq_o)
		else $error("interrupt missing for enabled flag");

	irq_quiet_a: assert property (
		!(|(event_status_flags & dma_interrupt_enable & TEF_IRQ_MASK))
		|=> !irq_o)
		else $error("interrupt without enabled flag");

	upd_dma_a: assert property (
		update_dma_req_o == $past(update_evt_i
		&& dma_interrupt_enable[TEF_UPD_DMA_BIT]))
		else $error("update DMA request wrong");

	trg_dma_a: assert property (
		trig_evt && !dma_interrupt_enable[TEF_TRG_DMA_BIT]
		|=> !trigger_dma_req_o)
		else $error("trigger DMA request while disabled");

	ch_dma_a: assert property (
		chan_evt[2] && dma_interrupt_enable[TEF_CH_DMA_LSB + 2]
		|=> chan_dma_req_o[2])
		else $error("channel 3 DMA request missing");

	dier_write_a: assert property (
		wr_en_dier && pstrb_i == 4'hF
		|=> dma_interrupt_enable == ($past(pwdata_i) & TEF_DIER_MASK))
		else $error("enable register write lost");

	overcap_c: cover property (
		chan_input_mode_i[0] && chan_capture_i[0]
		&& event_status_flags[TEF_CH_FLG_LSB]);
	clear_race_c: cover property (
		wr_en_sr && !pwdata_i[0] && update_evt_i);
	pause_fall_c: cover property (
		$fell(trigger_in_i) && slave_mode_select_i == TEF_SLV_PAUSE);
	irq_rise_c: cover property ($rose(irq_o));
endmodule

// File: verif/tef_req_sink.sv
// Sink model of the interrupt and DMA controllers, counting requests
`timescale 1ns/100ps
module tef_req_sink (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        irq_i,
	input  wire logic        upd_req_i,
	input  wire logic [3:0]  ch_req_i,
	input  wire logic        trg_req_i,
	output logic [31:0]      upd_cnt_o,
	output logic [31:0]      trg_cnt_o,
	output logic [31:0]      ch_cnt_o [4],
	output logic [31:0]      irq_rise_o
);
	logic irq_q;  // Last sampled interrupt level

	// Every high cycle is one request; pulses carry no handshake
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			upd_cnt_o  <= 32'h0;
			trg_cnt_o  <= 32'h0;
			ch_cnt_o   <= '{32'h0, 32'h0, 32'h0, 32'h0};
			irq_rise_o <= 32'h0;
			irq_q      <= 1'b0;
		end else begin
			upd_cnt_o <= upd_cnt_o + upd_req_i;
			trg_cnt_o <= trg_cnt_o + trg_req_i;
			for (int i = 0; i < 4; i++) begin
				ch_cnt_o[i] <= ch_cnt_o[i] + ch_req_i[i];
			end
			// Level input: only the rise is a new request
			irq_q      <= irq_i;
			irq_rise_o <= irq_rise_o + (irq_i & ~irq_q);
		end
	end
endmodule

// File: verif/tb_timer_event_flag_and_request_enable.sv
// Self-checking bench for the timer event flag and request logic
`timescale 1ns/100ps
module tb_timer_event_flag_and_request_enable;
	import tef_pkg::*;
	logic        ref_clk_i = 1'b0;  // 20 MHz kernel clock
	logic        sys_rst_i = 1'b1;  // Held high at start
	logic        psel      = 1'b0;  // APB request
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [11:0] paddr     = 12'h000;
	logic [31:0] pwdata    = 32'h0;
	logic [31:0] prdata;            // APB answer
	logic        pready;
	logic        pslverr;
	logic        upd       = 1'b0;  // Event stimulus
	logic [3:0]  cap       = 4'h0;
	logic [3:0]  cmp       = 4'h0;
	logic [3:0]  imode     = 4'h0;
	logic        tin       = 1'b0;
	logic [2:0]  smode     = 3'h0;
	logic        irq;               // Request outputs
	logic        upd_req;
	logic        trg_req;
	logic [3:0]  ch_req;
	logic [31:0] upd_n;             // Counts seen by the sink
	logic [31:0] trg_n;
	logic [31:0] irq_n;
	logic [31:0] ch_n [4];
	logic [31:0] rd;                // Last read data
	logic        er;                // Last error response
	logic [31:0] u;                 // Random draw
	logic [31:0] sr;                // Model status flags
	logic [31:0] ier;               // Model enables
	logic [2:0]  md;
	logic [3:0]  im;
	logic        prev_t;            // Model trigger history
	logic        c;
	logic        m;
	int          e_upd = 0;         // Expected request counts
	int          e_trg;
	int          e_ch [4];
	int          n_mismatch  = 0;
	int          check_count = 0;
	int          seed        = 64;
	logic [2:0]  modes [4] = '{3'h0, 3'h5, 3'h4, 3'h7};

	// Free-running clock, 50 ns period
	always #25 ref_clk_i = ~ref_clk_i;

	// Update DMA model: one request per cycle the event is seen
	// Counted here so a held event needs no assumed bus timing
	always @(posedge ref_clk_i) begin
		if (!sys_rst_i && upd) begin
			e_upd += ier[8];
		end
	end

	tef_flags dut_u (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.update_evt_i(upd), .chan_capture_i(cap),
		.chan_compare_i(cmp), .chan_input_mode_i(imode),
		.trigger_in_i(tin), .slave_mode_select_i(smode),
		.irq_o(irq), .update_dma_req_o(upd_req),
		.chan_dma_req_o(ch_req), .trigger_dma_req_o(trg_req));

	tef_req_sink sink_u (
		.clk_i(ref_clk_i), .rst_i(sys_rst_i), .irq_i(irq),
		.upd_req_i(upd_req), .ch_req_i(ch_req), .trg_req_i(trg_req),
		.upd_cnt_o(upd_n), .trg_cnt_o(trg_n), .ch_cnt_o(ch_n),
		.irq_rise_o(irq_n));

	// Count and report one comparison
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// Single exit point of the run
	task give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One APB transfer; waits for pready with a bound
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Main sequence
	initial begin
		sr = 32'h0;
		ier = 32'h0;
		prev_t = 1'b0;
		e_trg = 0;
		e_ch = '{0, 0, 0, 0};
		repeat (8) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		apb(1'b0, TEF_DIER_OFF, 32'h0);
		chk(rd, TEF_DIER_RST);
		apb(1'b0, TEF_SR_OFF, 32'h0);
		chk(rd, TEF_SR_RST);
		chk({31'h0, er}, 32'h0);
		// Unmapped place: refused, write dropped, reads zero
		apb(1'b1, 12'h014, 32'hFFFF);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		$display("register reset test done");
		for (int r = 0; r < 24; r++) begin
			// Random enables within the implemented bits only
			ier = 32'($random(seed)) & TEF_DIER_MASK;
			apb(1'b1, TEF_DIER_OFF, ier);
			apb(1'b0, TEF_DIER_OFF, 32'h0);
			chk(rd, ier);
			md = modes[r % 4];
			im = 4'($random(seed));
			smode <= md;
			imode <= im;
			for (int k = 0; k < 40; k++) begin
				@(posedge ref_clk_i);
				u = $random(seed);
				upd <= u[0] & u[1];
				cap <= u[5:2] & u[9:6];
				cmp <= u[13:10] & u[17:14];
				tin <= u[18];
				if (u[0] & u[1]) begin
					sr[0] = 1'b1;
				end
				for (int i = 0; i < 4; i++) begin
					// Direction decides which event counts
					c = u[2+i] & u[6+i] & im[i];
					m = u[10+i] & u[14+i] & ~im[i];
					if (c && sr[1+i]) sr[9+i] = 1'b1;
					if (c || m) begin
						sr[1+i] = 1'b1;
						e_ch[i] += ier[9+i];
					end
				end
				// Pause counts both edges; disabled counts none
				if (md != TEF_SLV_OFF && (md == TEF_SLV_PAUSE ?
					u[18] != prev_t : u[18] & ~prev_t)) begin
					sr[6] = 1'b1;
					e_trg += ier[14];
				end
				prev_t = u[18];
			end
			@(posedge ref_clk_i);
			upd <= 1'b0;
			cap <= 4'h0;
			cmp <= 4'h0;
			repeat (3) @(posedge ref_clk_i);
			apb(1'b0, TEF_SR_OFF, 32'h0);
			chk(rd, sr);
			chk({31'h0, irq}, {31'h0, |(sr & ier & TEF_IRQ_MASK)});
			chk(upd_n, e_upd);
			chk(trg_n, e_trg);
			for (int i = 0; i < 4; i++) chk(ch_n[i], e_ch[i]);
			// Zeros clear, ones keep
			u = 32'($random(seed)) & TEF_SR_MASK;
			// Odd rounds: an update event is held across the clearing
			// write, so the hardware set must beat the software clear
			if (r % 2 == 1) begin
				u[0] = 1'b0;
				upd <= 1'b1;
			end
			apb(1'b1, TEF_SR_OFF, u);
			upd <= 1'b0;
			sr &= u;
			if (r % 2 == 1) begin
				sr[0] = 1'b1;
			end
			apb(1'b0, TEF_SR_OFF, 32'h0);
			chk(rd, sr);
			chk({31'h0, irq}, {31'h0, |(sr & ier & TEF_IRQ_MASK)});
			$display("event round %0d done", r);
		end
		chk({31'h0, irq_n != 32'h0}, 32'h1);
		give_verdict();
	end
endmodule
